// ### timer16_capture_compare.sv
// 16-bit timer/event counter: capture, compare, output and overflow logic
// assumes a classic wishbone master and pins asynchronous to clk_i
//
// Our own choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ns
module timer16_capture_compare (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [5:2]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   input  wire logic        capture_input_a_i,
   input  wire logic        capture_input_b_i,
   output logic             timer_output_pin_o,
   output logic             first_match_irq_o,
   output logic             second_match_irq_o
);
   logic [7:0]  mode_control_reg;
   logic [7:0]  capture_ctrl_reg;
   logic [7:0]  output_control_reg;
   logic [7:0]  prescaler_reg;
   logic [15:0] count_reg;
   logic [15:0] capcomp_first_reg;
   logic [15:0] capcomp_second_reg;
   logic        out_level_reg;
   logic        os_active_reg;
   logic        ack_reg;
   logic [31:0] rdata_reg;
   logic        first_irq_reg;
   logic        second_irq_reg;
   logic        first_irq_pend_reg;
   logic        second_irq_pend_reg;
   logic        ovf_hold_reg;
   logic [1:0]  mode;
   logic        running;
   logic        tick;
   logic        a_valid;
   logic        a_reverse;
   logic        b_valid;
   logic        take;
   logic        wr;
   logic        rd;
   logic        match_first;
   logic        match_second;
   logic        capture_mode_first;
   logic        capture_mode_second;
   logic        first_cap_evt;
   logic        second_cap_evt;
   logic        first_irq_evt;
   logic        clear_count;
   logic        overflow_evt;
   logic        os_trigger;
   logic [15:0] count_next;

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] be);
      merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
   endfunction

   function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d, input logic [3:0] be);
      merge8 = be[0] ? d[7:0] : old;
   endfunction

   assign mode    = mode_control_reg[timer16_pkg::MODE_SEL_LO_BIT +: 2];
   assign running = (mode != timer16_pkg::MODE_STOP);
   // a request is taken while ack is low; a write lands at the edge where the master sees ack
   assign take    = cyc_i && stb_i && !ack_reg;
   assign wr      = cyc_i && stb_i && we_i && ack_reg;
   assign rd      = take && !we_i;

   timer16_prescaler #(
      .WIDTH (8)
   ) u_prescaler (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .run_i  (running),
      .sel_i  (prescaler_reg[2:0]),
      .tick_o (tick)
   );

   timer16_edge_detect u_edge_a (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .pin_i      (capture_input_a_i),
      .sample_i   (tick),
      .run_i      (running),
      .edge_sel_i (capture_ctrl_reg[5:4]),
      .valid_o    (a_valid),
      .reverse_o  (a_reverse)
   );

   timer16_edge_detect u_edge_b (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .pin_i      (capture_input_b_i),
      .sample_i   (tick),
      .run_i      (running),
      .edge_sel_i (capture_ctrl_reg[7:6]),
      .valid_o    (b_valid),
      .reverse_o  ()
   );

   // capture_ctrl bit 2 makes the first register a capture register, bit 3 the second
   assign capture_mode_first  = capture_ctrl_reg[2];
   assign capture_mode_second = capture_ctrl_reg[3];

   // trigger source for the first register: input A, input B, or input A reverse edge
   assign first_cap_evt  = capture_mode_first &&
                           (capture_ctrl_reg[timer16_pkg::CAP_FIRST_REV_A] ? a_reverse :
                            (capture_ctrl_reg[timer16_pkg::CAP_FIRST_SEL_B] ? b_valid : a_valid));
   assign second_cap_evt = capture_mode_second && a_valid;
   // reverse-edge capture raises no interrupt; a B edge still does, as an external event
   assign first_irq_evt  = capture_mode_first ?
                           (capture_ctrl_reg[timer16_pkg::CAP_FIRST_REV_A] ? b_valid : first_cap_evt) :
                           match_first;

   assign match_first  = tick && !capture_mode_first && (count_reg == capcomp_first_reg);
   assign match_second = tick && !capture_mode_second && (count_reg == capcomp_second_reg);

   assign os_trigger = output_control_reg[timer16_pkg::OUT_OS_EN_BIT] &&
                       (output_control_reg[timer16_pkg::OUT_OS_TRIG_BIT] ||
                        (tick && a_valid && mode == timer16_pkg::MODE_CLR_EDGE_A));

   always_comb begin
      clear_count  = 1'b0;
      overflow_evt = 1'b0;
      count_next   = count_reg + 16'h0001;
      case (mode)
         timer16_pkg::MODE_CLR_EDGE_A: begin
            clear_count = a_valid;
         end
         timer16_pkg::MODE_CLR_MATCH: begin
            clear_count = match_first;
         end
         default: begin
            clear_count = 1'b0;
         end
      endcase
      if (clear_count || os_trigger) begin
         count_next = timer16_pkg::COUNT_ZERO;
      end
      if (count_reg == timer16_pkg::COUNT_MAX) begin
         overflow_evt = tick;
      end
   end

   // count on count clock ticks and on a one-shot trigger; the divider restarts with the timer, so the first tick comes in the first running cycle
   always_ff @(posedge clk_i) begin
      if (rst_i || !running) begin
         count_reg <= timer16_pkg::COUNT_ZERO;
      end else if (tick || os_trigger) begin
         count_reg <= count_next;
      end
   end

   // flag stays set until the count leaves 0000H, so an early clear is undone
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ovf_hold_reg <= 1'b0;
      end else if (overflow_evt) begin
         ovf_hold_reg <= 1'b1;
      end else if (tick) begin
         ovf_hold_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_control_reg <= timer16_pkg::REG8_RESET;
      end else begin
         if (wr && adr_i == timer16_pkg::ADDR_MODE) begin
            mode_control_reg <= merge8(mode_control_reg, dat_i, sel_i);
         end
         if (overflow_evt || ovf_hold_reg) begin
            mode_control_reg[timer16_pkg::MODE_OVF_BIT] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         capture_ctrl_reg <= timer16_pkg::REG8_RESET;
      end else if (wr && adr_i == timer16_pkg::ADDR_CAPCTRL) begin
         capture_ctrl_reg <= merge8(capture_ctrl_reg, dat_i, sel_i);
      end
   end

   // the divider select is read live, so changing it while running shifts the next tick
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prescaler_reg <= timer16_pkg::REG8_RESET;
      end else if (wr && adr_i == timer16_pkg::ADDR_PRESCALE) begin
         prescaler_reg <= merge8(prescaler_reg, dat_i, sel_i);
      end
   end

   // the one-shot trigger bit is self-clearing
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         output_control_reg <= timer16_pkg::REG8_RESET;
      end else if (wr && adr_i == timer16_pkg::ADDR_OUTCTRL) begin
         output_control_reg <= merge8(output_control_reg, dat_i, sel_i);
      end else begin
         output_control_reg[timer16_pkg::OUT_OS_TRIG_BIT] <= 1'b0;
         output_control_reg[timer16_pkg::OUT_SET_BIT]     <= 1'b0;
         output_control_reg[timer16_pkg::OUT_CLEAR_BIT]   <= 1'b0;
      end
   end

   // captures win over bus writes; contents after stop are whatever was last held
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         capcomp_first_reg <= timer16_pkg::REG16_RESET;
      end else if (first_cap_evt) begin
         capcomp_first_reg <= count_reg;
      end else if (wr && adr_i == timer16_pkg::ADDR_CC_FIRST) begin
         capcomp_first_reg <= merge16(capcomp_first_reg, dat_i, sel_i);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         capcomp_second_reg <= timer16_pkg::REG16_RESET;
      end else if (second_cap_evt) begin
         capcomp_second_reg <= count_reg;
      end else if (wr && adr_i == timer16_pkg::ADDR_CC_SECOND) begin
         capcomp_second_reg <= merge16(capcomp_second_reg, dat_i, sel_i);
      end
   end

   // preset acts only while stopped; running output toggles on matches
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_level_reg <= 1'b0;
      end else if (!running) begin
         case ({output_control_reg[timer16_pkg::OUT_SET_BIT], output_control_reg[timer16_pkg::OUT_CLEAR_BIT]})
            2'h1: out_level_reg <= 1'b0;
            2'h2: out_level_reg <= 1'b1;
            default: out_level_reg <= out_level_reg;
         endcase
      end else if ((match_first && output_control_reg[timer16_pkg::OUT_TOG1_BIT]) ^
                   (match_second && output_control_reg[timer16_pkg::OUT_TOG2_BIT])) begin
         out_level_reg <= !out_level_reg;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || !running) begin
         os_active_reg <= 1'b0;
      end else if (os_trigger) begin
         os_active_reg <= 1'b1;
      end else if (match_second) begin
         os_active_reg <= 1'b0;
      end
   end

   assign timer_output_pin_o = output_control_reg[timer16_pkg::OUT_ENABLE_BIT] && out_level_reg;

   // interrupts appear one count clock after the capture or match
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         first_irq_pend_reg <= 1'b0;
         first_irq_reg      <= 1'b0;
      end else begin
         first_irq_reg <= 1'b0;
         if (first_irq_evt) begin
            first_irq_pend_reg <= 1'b1;
         end else if (tick && first_irq_pend_reg) begin
            first_irq_pend_reg <= 1'b0;
            first_irq_reg      <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         second_irq_pend_reg <= 1'b0;
         second_irq_reg      <= 1'b0;
      end else begin
         second_irq_reg <= 1'b0;
         if (second_cap_evt || match_second) begin
            second_irq_pend_reg <= 1'b1;
         end else if (tick && second_irq_pend_reg) begin
            second_irq_pend_reg <= 1'b0;
            second_irq_reg      <= 1'b1;
         end
      end
   end

   assign first_match_irq_o  = first_irq_reg;
   assign second_match_irq_o = second_irq_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= take;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_reg <= 32'h00000000;
      end else begin
         if (rd) begin
            case (adr_i)
               timer16_pkg::ADDR_MODE:       rdata_reg <= {24'h000000, mode_control_reg};
               timer16_pkg::ADDR_CAPCTRL:    rdata_reg <= {24'h000000, capture_ctrl_reg};
               timer16_pkg::ADDR_OUTCTRL:    rdata_reg <= {24'h000000, output_control_reg};
               timer16_pkg::ADDR_PRESCALE:   rdata_reg <= {24'h000000, prescaler_reg};
               timer16_pkg::ADDR_COUNT:      rdata_reg <= {16'h0000, count_reg};
               timer16_pkg::ADDR_CC_FIRST:   rdata_reg <= {16'h0000, capcomp_first_reg};
               timer16_pkg::ADDR_CC_SECOND:  rdata_reg <= {16'h0000, capcomp_second_reg};
               timer16_pkg::ADDR_IRQ_STATUS: rdata_reg <= {28'h0000000, os_active_reg, out_level_reg,
                                                           second_irq_pend_reg, first_irq_pend_reg};
               default:                      rdata_reg <= 32'h00000000;
            endcase
         end
      end
   end

   assign ack_o = ack_reg;
   assign dat_o = rdata_reg;
endmodule

// ### timer16_pkg.sv
// constants shared by the 16-bit capture/compare timer files
// assumes a single 100 MHz clock and a classic wishbone register bus
package timer16_pkg;
   localparam int          CLK_MHZ          = 100;
   localparam logic [3:0]  ADDR_MODE        = 4'h0;
   localparam logic [3:0]  ADDR_CAPCTRL     = 4'h1;
   localparam logic [3:0]  ADDR_OUTCTRL     = 4'h2;
   localparam logic [3:0]  ADDR_PRESCALE    = 4'h3;
   localparam logic [3:0]  ADDR_COUNT       = 4'h4;
   localparam logic [3:0]  ADDR_CC_FIRST    = 4'h5;
   localparam logic [3:0]  ADDR_CC_SECOND   = 4'h6;
   localparam logic [3:0]  ADDR_IRQ_STATUS  = 4'h7;
   localparam logic [1:0]  MODE_STOP        = 2'h0;
   localparam logic [1:0]  MODE_FREE        = 2'h1;
   localparam logic [1:0]  MODE_CLR_EDGE_A  = 2'h2;
   localparam logic [1:0]  MODE_CLR_MATCH   = 2'h3;
   localparam int          MODE_OVF_BIT     = 0;
   localparam int          MODE_SEL_LO_BIT  = 2;
   localparam int          CAP_FIRST_SEL_B  = 0;
   localparam int          CAP_FIRST_REV_A  = 1;
   localparam int          OUT_ENABLE_BIT   = 0;
   localparam int          OUT_TOG1_BIT     = 1;
   localparam int          OUT_CLEAR_BIT    = 2;
   localparam int          OUT_SET_BIT      = 3;
   localparam int          OUT_TOG2_BIT     = 4;
   localparam int          OUT_OS_EN_BIT    = 5;
   localparam int          OUT_OS_TRIG_BIT  = 6;
   localparam logic [15:0] COUNT_MAX        = 16'hFFFF;
   localparam logic [15:0] COUNT_ZERO       = 16'h0000;
   localparam logic [7:0]  REG8_RESET       = 8'h00;
   localparam logic [15:0] REG16_RESET      = 16'h0000;
   localparam logic [1:0]  EDGE_FALL        = 2'h0;
   localparam logic [1:0]  EDGE_RISE        = 2'h1;
   localparam logic [1:0]  EDGE_BOTH        = 2'h3;
endpackage

// ### timer16_prescaler.sv
// count clock enable divider: one-cycle pulse every 2**sel cycles
// assumes sel is held steady while the timer runs
`timescale 1ns/1ns
module timer16_prescaler #(
   parameter int WIDTH = 8
) (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       run_i,
   input  wire logic [2:0] sel_i,
   output logic            tick_o
);
   logic [WIDTH-1:0] div_reg;
   logic [WIDTH-1:0] mask;

   assign mask   = WIDTH'((1 << sel_i) - 1);
   assign tick_o = run_i && ((div_reg & mask) == '0);

   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + WIDTH'(1);
      end
   end
endmodule

// ### timer16_edge_detect.sv
// pin synchroniser with two-sample noise filter and edge select
// assumes the pin is asynchronous to clk_i
`timescale 1ns/1ns
module timer16_edge_detect (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       pin_i,
   input  wire logic       sample_i,
   input  wire logic       run_i,
   input  wire logic [1:0] edge_sel_i,
   output logic            valid_o,
   output logic            reverse_o
);
   logic sync1_reg;
   logic sync2_reg;
   logic samp_reg;
   logic level_reg;
   logic rise;
   logic fall;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
      end else begin
         sync1_reg <= pin_i;
         sync2_reg <= sync1_reg;
      end
   end

   // a level counts only after two equal samples on the count clock
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         samp_reg  <= 1'b0;
         level_reg <= 1'b0;
      end else if (sample_i) begin
         samp_reg <= sync2_reg;
         if (samp_reg == sync2_reg) begin
            level_reg <= sync2_reg;
         end
      end
   end

   assign rise = sample_i && run_i && (samp_reg == sync2_reg) && sync2_reg && !level_reg;
   assign fall = sample_i && run_i && (samp_reg == sync2_reg) && !sync2_reg && level_reg;

   always_comb begin
      case (edge_sel_i)
         timer16_pkg::EDGE_FALL: begin
            valid_o   = fall;
            reverse_o = rise;
         end
         timer16_pkg::EDGE_RISE: begin
            valid_o   = rise;
            reverse_o = fall;
         end
         timer16_pkg::EDGE_BOTH: begin
            valid_o   = rise | fall;
            reverse_o = 1'b0;
         end
         default: begin
            valid_o   = 1'b0;
            reverse_o = 1'b0;
         end
      endcase
   end
endmodule

// ### timer16_cc_properties.sv
// port-level checker for the 16-bit capture/compare timer
// assumes classic wishbone writes take effect at the ack edge
`timescale 1ns/1ns
module timer16_cc_properties (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [5:2]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   input  wire logic [31:0] dat_o,
   input  wire logic        ack_o,
   input  wire logic        capture_input_a_i,
   input  wire logic        capture_input_b_i,
   input  wire logic        timer_output_pin_o,
   input  wire logic        first_match_irq_o,
   input  wire logic        second_match_irq_o
);
   logic [1:0] mode_reg;
   logic [7:0] cap_reg;
   logic [7:0] out_reg;
   logic [2:0] pre_reg;
   logic       wr_ok;
   logic       rev_a_only;
   assign wr_ok = ack_o && cyc_i && stb_i && we_i && sel_i[0];
   assign rev_a_only = cap_reg[timer16_pkg::CAP_FIRST_REV_A] && !cap_reg[timer16_pkg::CAP_FIRST_SEL_B]
                       && cap_reg[2] && cap_reg[7:6] == 2'h2;
   // shadow copies of the control bytes, so properties know the mode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_reg <= 2'h0;
         cap_reg  <= 8'h00;
         out_reg  <= 8'h00;
         pre_reg  <= 3'h0;
      end else if (wr_ok) begin
         if (adr_i == timer16_pkg::ADDR_PRESCALE) pre_reg <= dat_i[2:0];
         if (adr_i == timer16_pkg::ADDR_MODE) mode_reg <= dat_i[3:2];
         if (adr_i == timer16_pkg::ADDR_CAPCTRL) cap_reg <= dat_i[7:0];
         if (adr_i == timer16_pkg::ADDR_OUTCTRL) out_reg <= dat_i[7:0];
      end
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   AST_ACK_NEXT: // bus handshake, one cycle latency
      assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack missing after request");
   AST_ACK_PULSE: // bus handshake
      assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
   AST_UNMAPPED_ZERO: // unmapped reads
      assert property (ack_o && !we_i && adr_i[5] |-> dat_o == 32'h0) else $error("unmapped read not zero");
   AST_RESET_QUIET:
      assert property (disable iff (1'b0) rst_i |=> !ack_o && !timer_output_pin_o && !first_match_irq_o)
         else $error("outputs active after reset");
   AST_PRESET_HIGH:
      assert property (wr_ok && adr_i == timer16_pkg::ADDR_OUTCTRL && dat_i[3:2] == 2'h2 && dat_i[0]
         && mode_reg == timer16_pkg::MODE_STOP |-> ##[1:3] timer_output_pin_o) else $error("preset high lost");
   AST_PRESET_LOW:
      assert property (wr_ok && adr_i == timer16_pkg::ADDR_OUTCTRL && dat_i[3:2] == 2'h1
         && mode_reg == timer16_pkg::MODE_STOP |-> ##[1:3] !timer_output_pin_o) else $error("preset low lost");
   AST_TOGGLE_FIRST:
      assert property (first_match_irq_o && !second_match_irq_o && out_reg[1:0] == 2'h3 && pre_reg == 3'h0
         && mode_reg == timer16_pkg::MODE_CLR_MATCH
         |-> $past(timer_output_pin_o, 2) != $past(timer_output_pin_o))
         else $error("output not inverted on first match");
   AST_NO_FIRST_IRQ_REV_A:
      assert property (mode_reg != timer16_pkg::MODE_STOP && rev_a_only |-> !first_match_irq_o)
         else $error("first interrupt on reverse edge capture");
   AST_IRQ2_PULSE:
      assert property (second_match_irq_o |=> !second_match_irq_o) else $error("second irq not a pulse");
endmodule
bind timer16_capture_compare timer16_cc_properties i_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
   .capture_input_a_i(capture_input_a_i), .capture_input_b_i(capture_input_b_i),
   .timer_output_pin_o(timer_output_pin_o), .first_match_irq_o(first_match_irq_o),
   .second_match_irq_o(second_match_irq_o));

// ### pin_pulser.sv
// external pulse source for the two capture pins
// assumes high_i/low_i stay steady while run_i is high
`timescale 1ns/1ns
module pin_pulser (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        run_i,
   input  wire logic [15:0] high_i,
   input  wire logic [15:0] low_i,
   input  wire logic [3:0]  lag_i,
   output logic             a_o,
   output logic             b_o
);
   logic [15:0] cnt_reg;
   logic [15:0] hist_reg;
   // a source that is off rests low; it is a driven pin, never released
   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         cnt_reg <= 16'h0001;
         a_o     <= 1'b0;
      end else if (cnt_reg >= (a_o ? high_i : low_i)) begin
         cnt_reg <= 16'h0001;
         a_o     <= ~a_o;
      end else begin
         cnt_reg <= cnt_reg + 16'h0001;
      end
   end
   always_ff @(posedge clk_i) begin
      hist_reg <= rst_i ? 16'h0000 : {hist_reg[14:0], a_o};
   end
   // second pin copies the first, lag_i cycles later
   assign b_o = hist_reg[lag_i - 4'h1];
endmodule

// ### tb.sv
// self-checking bench for the capture/compare timer
// assumes a 100 MHz clock and a single-cycle wishbone master
`timescale 1ns/1ns
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin error_cnt++; \
   $display("[ERR] t=%0t got %h exp %h", $time, (got), (exp)); end end
module tb;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc_i = 1'b0;
   logic        stb_i = 1'b0;
   logic        we_i  = 1'b0;
   logic [5:2]  adr_i = 4'h0;
   logic [3:0]  sel_i = 4'hF;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o;
   logic        ack_o;
   logic        pin_a;
   logic        pin_b;
   logic        pin_o;
   logic        irq1;
   logic        irq2;
   logic        pul_run = 1'b0;
   logic [15:0] hi_len  = 16'h0008;
   logic [15:0] lo_len  = 16'h0008;
   logic [31:0] f;
   logic [31:0] s;
   logic [15:0] prev;
   int          error_cnt = 0;
   int          checked   = 0;
   int          irq1_cnt  = 0;
   int          seed;
   int          n;
   always #5 clk_i = ~clk_i;
   timer16_capture_compare i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .capture_input_a_i(pin_a),
      .capture_input_b_i(pin_b), .timer_output_pin_o(pin_o), .first_match_irq_o(irq1),
      .second_match_irq_o(irq2));
   pin_pulser i_pins (.clk_i(clk_i), .rst_i(rst_i), .run_i(pul_run), .high_i(hi_len), .low_i(lo_len),
      .lag_i(4'h3), .a_o(pin_a), .b_o(pin_b));
   always @(posedge clk_i) if (irq1 === 1'b1) irq1_cnt++;
   function automatic logic [15:0] rand_len();
      return 16'(6 + $unsigned($random(seed)) % 35);
   endfunction
   task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
      int k;
      k = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack_o !== 1'b1 && k < 20);
      if (k >= 20) begin error_cnt++; $display("[ERR] t=%0t no ack", $time); end
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(a, 1'b1, d, q);
   endtask
   task automatic wait_irq(input bit second, input int lim, output int k);
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while ((second ? irq2 : irq1) !== 1'b1 && k < lim);
      if (k >= lim) begin error_cnt++; $display("[ERR] t=%0t irq timeout", $time); end
   endtask
   task automatic tally_and_finish();
      $display("counts: checked=%0d errors=%0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (80000) @(posedge clk_i);
      error_cnt++;
      tally_and_finish();
   end
   initial begin
      seed = 32'h3f524fc8;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 8; i++) begin wb(4'(i), 1'b0, 32'h0, s); `CHK(s, 32'h0) end
      wr(4'hC, 32'hFFFFFFFF);
      wb(4'hC, 1'b0, 32'h0, s);
      `CHK(s, 32'h0)
      $display("test registers done");
      for (int m = 0; m < 2; m++) begin
         hi_len <= rand_len();
         lo_len <= rand_len();
         wr(timer16_pkg::ADDR_CAPCTRL, 32'h9E);
         wr(timer16_pkg::ADDR_OUTCTRL, 32'h0);
         wr(timer16_pkg::ADDR_PRESCALE, 32'h0);
         wr(timer16_pkg::ADDR_MODE, m == 0 ? 32'h4 : 32'h8);
         irq1_cnt = 0;
         pul_run <= 1'b1;
         // the first edge after start may be a start-up artefact
         wait_irq(1'b1, 400, n);
         wb(timer16_pkg::ADDR_CC_SECOND, 1'b0, 32'h0, s);
         prev = s[15:0];
         for (int k = 0; k < 3; k++) begin
            wait_irq(1'b1, 400, n);
            wb(timer16_pkg::ADDR_CC_FIRST, 1'b0, 32'h0, f);
            wb(timer16_pkg::ADDR_CC_SECOND, 1'b0, 32'h0, s);
            `CHK(s[15:0] - f[15:0], lo_len)
            if (m == 0) `CHK(s[15:0] - prev, hi_len + lo_len)
            else `CHK(s[15:0] - (hi_len + lo_len) + 16'h1 <= 16'h2, 1'b1)
            prev = s[15:0];
         end
         `CHK(irq1_cnt, 0)
         pul_run <= 1'b0;
         wr(timer16_pkg::ADDR_MODE, 32'h0);
         $display("test measurement mode %0d done", m);
      end
      wr(timer16_pkg::ADDR_CAPCTRL, 32'h5D);
      wr(timer16_pkg::ADDR_MODE, 32'h4);
      pul_run <= 1'b1;
      wait_irq(1'b0, 400, n);
      wait_irq(1'b0, 400, n);
      wb(timer16_pkg::ADDR_CC_FIRST, 1'b0, 32'h0, f);
      wb(timer16_pkg::ADDR_CC_SECOND, 1'b0, 32'h0, s);
      `CHK(f[15:0] - s[15:0], 16'h0003)
      pul_run <= 1'b0;
      wr(timer16_pkg::ADDR_MODE, 32'h0);
      $display("test input b capture done");
      wr(timer16_pkg::ADDR_CAPCTRL, 32'hA0);
      wr(timer16_pkg::ADDR_OUTCTRL, 32'h09);
      repeat (3) @(posedge clk_i);
      `CHK(pin_o, 1'b1)
      wr(timer16_pkg::ADDR_OUTCTRL, 32'h05);
      repeat (3) @(posedge clk_i);
      `CHK(pin_o, 1'b0)
      wr(timer16_pkg::ADDR_OUTCTRL, 32'h09);
      wr(timer16_pkg::ADDR_OUTCTRL, 32'h03);
      repeat (3) @(posedge clk_i);
      `CHK(pin_o, 1'b1)
      wr(timer16_pkg::ADDR_CC_FIRST, 32'h14);
      wr(timer16_pkg::ADDR_CC_SECOND, 32'h0A);
      wr(timer16_pkg::ADDR_MODE, 32'hC);
      `CHK(pin_o, 1'b1)
      wait_irq(1'b0, 100, n);
      repeat (2) @(posedge clk_i);
      `CHK(pin_o, 1'b0)
      wait_irq(1'b0, 100, n);
      `CHK(n, 19)
      repeat (2) @(posedge clk_i);
      `CHK(pin_o, 1'b1)
      wr(timer16_pkg::ADDR_MODE, 32'h0);
      $display("test output preset done");
      wr(timer16_pkg::ADDR_OUTCTRL, 32'h0);
      wr(timer16_pkg::ADDR_CC_FIRST, 32'hFFFF);
      wr(timer16_pkg::ADDR_MODE, 32'hC);
      wait_irq(1'b0, 70000, n);
      wb(timer16_pkg::ADDR_MODE, 1'b0, 32'h0, s);
      `CHK(s[0], 1'b1)
      wr(timer16_pkg::ADDR_MODE, 32'hC);
      wb(timer16_pkg::ADDR_MODE, 1'b0, 32'h0, s);
      `CHK(s[0], 1'b0)
      $display("test overflow done");
      tally_and_finish();
   end
endmodule
